// ---- hdl/csl_pkg.sv ----
`default_nettype none
package csl_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned FLASH_HZ        = 2;
  localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / (2 * FLASH_HZ);
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned LINK_ACTIVITY_LAMP_HOLD_MS    = 50;
  localparam int unsigned LINK_ACTIVITY_LAMP_HOLD_CYC   = (CLK_HZ / 1000) * LINK_ACTIVITY_LAMP_HOLD_MS;
  localparam int unsigned CNT_W           = 26;

  // io widths
  localparam int unsigned NUM_IN          = 16;
  localparam int unsigned NUM_OUT         = 16;
  localparam int unsigned NUM_SW          = 3;

  // switch index
  localparam int unsigned SW_PORT_IDX     = 0;
  localparam int unsigned SW_USER_IDX     = 1;
  localparam int unsigned SW_BATT_IDX     = 2;

  // fixed framing
  localparam logic [3:0]  FIX_DATA_BITS   = 4'h7;
  localparam logic [1:0]  FIX_STOP_BITS   = 2'h2;
  localparam logic [1:0]  FIX_START_BITS  = 2'h1;
  localparam logic [15:0] FIX_BAUD        = 16'h2580;
  localparam logic [1:0]  PARITY_EVEN     = 2'h1;
  localparam int unsigned SETUP_WORDS     = 5;

  // register offsets
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_EN     = 8'h10;
  localparam logic [7:0]  ADDR_SETUP0     = 8'h20;
  localparam logic [7:0]  ADDR_SETUP4     = 8'h30;

  // ctrl fields
  localparam int unsigned CTRL_NOCLK_BIT  = 0;
  localparam int unsigned CTRL_SETUPCLR_BIT = 1;
  localparam int unsigned CTRL_BATTEN_BIT = 2;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // irq event bits
  localparam int unsigned EV_FATAL        = 0;
  localparam int unsigned EV_NONFATAL     = 1;
  localparam int unsigned EV_LOWBATT      = 2;
  localparam int unsigned EV_USERSW       = 3;
  localparam int unsigned NUM_EV          = 4;

  typedef enum logic [1:0] {
    MODE_EDIT,
    MODE_EXECUTE,
    MODE_OBSERVE
  } csl_mode_type;

  typedef struct packed {
    logic [15:0] baud;
    logic [3:0]  data_bits;
    logic [1:0]  stop_bits;
    logic [1:0]  start_bits;
    logic [1:0]  parity;
    logic        console_mode;
    logic        use_setup;
  } csl_port_cfg_type;

  typedef struct packed {
    logic power;
    logic execute;
    logic link_activity;
    logic fault;
    logic console_sel;
  } csl_lamps_type;
endpackage : csl_pkg
`default_nettype wire

// ---- hdl/csl_flasher.sv ----
`default_nettype none
module csl_flasher
  import csl_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // blink phase
  output logic      phase
);
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             phase_reg, phase_next;

  // slow square wave shared by every flashing lamp
  always_comb begin
    cnt_next   = cnt_reg + CNT_W'(1);
    phase_next = phase_reg;
    if (cnt_reg == CNT_W'(FLASH_HALF_CYC - 1)) begin
      cnt_next   = '0;
      phase_next = ~phase_reg;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg   <= '0;
      phase_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
endmodule : csl_flasher
`default_nettype wire

// ---- hdl/csl_debounce.sv ----
`default_nettype none
module csl_debounce
  import csl_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
)(
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // raw pin and clean level
  input  wire logic raw,
  output logic      clean
);
  logic             s1_reg, s2_reg;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             clean_reg, clean_next;

  // count only while the synced level disagrees with the output
  always_comb begin
    cnt_next   = '0;
    clean_next = clean_reg;
    if (s2_reg != clean_reg) begin
      cnt_next = cnt_reg + CNT_W'(1);
      if (cnt_reg == CNT_W'(STABLE_CYC - 1)) begin
        clean_next = s2_reg;
        cnt_next   = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      cnt_reg   <= '0;
      clean_reg <= 1'b0;
    end else begin
      s1_reg    <= raw;
      s2_reg    <= s1_reg;
      cnt_reg   <= cnt_next;
      clean_reg <= clean_next;
    end
  end

  assign clean = clean_reg;
endmodule : csl_debounce
`default_nettype wire

// ---- hdl/csl_status_panel.sv ----
// Register access over APB and the register addresses were left to the implementer.
`default_nettype none
// Function
// - power lamp lit while supply present, dark otherwise.
// - execute lamp lit in execute or observe mode; off in edit or fatal.
// - link lamp flashes while port transfers data; off when idle.
// - fault lamp steady on fatal, flashing on non-fatal, off when normal.
// - on older revisions, console-select lamp lit when set for console.
// - input lamps follow live terminals, counter inputs included.
// - input lamps track while stopped; input memory bits not refreshed.
// - short interrupt pulses need not be stretched for the lamps.
// - output lamps follow outputs, updated at I/O refresh, pulse outputs too.
// - port switch off: serial parameters come from five setup words (only words 0 and 1 are read).
// - port switch on: fixed 1 start, 7 data, 2 stop, even, 9600.
// - attached console forces console mode on the peripheral port only, whatever the port switch.
// - user flag bit follows user switch in every mode.
// - low-battery errors reported only with detect switch forward.
// - no-clock units default detection off; setup clear enables it and flags error.
// - one connector serves peripheral and serial functions at once.
module csl_status_panel
  import csl_pkg::*;
#(
  parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
  parameter int unsigned HOLD_CYC  = LINK_ACTIVITY_LAMP_HOLD_CYC,
  parameter bit          OLD_REV   = 1'b1
)(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // controller state
  input  wire logic                supply_ok,
  input  wire csl_mode_type        mode,
  input  wire logic                fatal_err,
  input  wire logic                nonfatal_err,
  input  wire logic                periph_xfer,
  input  wire logic                serial_xfer,
  input  wire logic                console_attached,
  input  wire logic                batt_low,
  input  wire logic                io_refresh,
  input  wire logic [NUM_OUT-1:0]  out_terms,
  // panel pins
  input  wire logic [NUM_IN-1:0]   in_terms,
  input  wire logic [NUM_SW-1:0]   panel_sw,
  // panel lamps
  output csl_lamps_type            lamps,
  output logic [NUM_IN-1:0]        in_lamps,
  output logic [NUM_OUT-1:0]       out_lamps,
  // controller side results
  output logic [NUM_IN-1:0]        in_bits,
  output csl_port_cfg_type         periph_cfg,
  output csl_port_cfg_type         serial_cfg,
  output logic                     user_switch_flag_bit,
  output logic                     low_batt_error,
  output logic                     irq
);
  logic                 flash;
  logic [NUM_SW-1:0]    sw_clean;
  logic                 port_setting_switch;
  logic                 user_flag_switch;
  logic                 batt_detect_switch;

  logic [NUM_IN-1:0]    in_s1_reg, in_s2_reg;
  logic [NUM_IN-1:0]    in_bits_reg, in_bits_next;
  logic [NUM_OUT-1:0]   out_lamps_reg, out_lamps_next;
  logic [31:0]          ctrl_reg, ctrl_next;
  logic [31:0]          setup_reg [SETUP_WORDS];
  logic [31:0]          setup_next [SETUP_WORDS];
  logic [NUM_EV-1:0]    ev_stat_reg, ev_stat_next;
  logic [NUM_EV-1:0]    ev_en_reg, ev_en_next;
  logic [NUM_EV-1:0]    ev_raw;
  logic [NUM_EV-1:0]    ev_prev_reg;
  logic [31:0]          prdata_reg, prdata_next;
  logic [CNT_W-1:0]     hold_reg, hold_next;
  logic                 user_flag_reg, user_flag_next;
  logic                 low_batt_reg, low_batt_next;
  logic                 running;
  logic                 wr_en, rd_en;
  logic                 addr_ok;
  logic [SETUP_WORDS-1:0] setup_hit;
  csl_lamps_type        lamps_reg, lamps_next;
  csl_port_cfg_type     fixed_cfg, setup_cfg;

  csl_flasher u_flash (
    .mclk  (mclk),
    .nrst  (nrst),
    .phase (flash)
  );

  // one debouncer per panel switch
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SW; gi++) begin : g_sw
      csl_debounce #(
        .STABLE_CYC (DEB_CYC)
      ) u_deb (
        .mclk  (mclk),
        .nrst  (nrst),
        .raw   (panel_sw[gi]),
        .clean (sw_clean[gi])
      );
    end
  endgenerate

  assign port_setting_switch = sw_clean[SW_PORT_IDX];
  assign user_flag_switch    = sw_clean[SW_USER_IDX];
  assign batt_detect_switch  = sw_clean[SW_BATT_IDX];

  // one address match per setup word
  generate
    for (gi = 0; gi < SETUP_WORDS; gi++) begin : g_setup
      assign setup_hit[gi] = (paddr == ADDR_SETUP0 + 8'(4 * gi));
    end
  endgenerate

  // apb: zero wait states, every access answered at once
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  // only aligned mapped words answer cleanly, the rest take an error
  always_comb begin
    case (paddr)
      ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN: addr_ok = 1'b1;
      default:                                                         addr_ok = |setup_hit;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = prdata_reg;

  assign running = (mode == MODE_EXECUTE) || (mode == MODE_OBSERVE);

  // events feeding the sticky status
  assign ev_raw[EV_FATAL]    = fatal_err;
  assign ev_raw[EV_NONFATAL] = nonfatal_err;
  assign ev_raw[EV_LOWBATT]  = low_batt_reg;
  assign ev_raw[EV_USERSW]   = user_flag_reg ^ user_flag_switch;

  always_comb begin
    fixed_cfg              = '0;
    fixed_cfg.baud         = FIX_BAUD;
    fixed_cfg.data_bits    = FIX_DATA_BITS;
    fixed_cfg.stop_bits    = FIX_STOP_BITS;
    fixed_cfg.start_bits   = FIX_START_BITS;
    fixed_cfg.parity       = PARITY_EVEN;
    // setup words carry framing in the low half of word 0, baud in word 1
    setup_cfg              = '0;
    setup_cfg.use_setup    = 1'b1;
    setup_cfg.baud         = setup_reg[1][15:0];
    setup_cfg.data_bits    = setup_reg[0][3:0];
    setup_cfg.stop_bits    = setup_reg[0][5:4];
    setup_cfg.start_bits   = setup_reg[0][7:6];
    setup_cfg.parity       = setup_reg[0][9:8];
  end

  always_comb begin
    // one shared source keeps both functions on the connector live together
    periph_cfg              = port_setting_switch ? fixed_cfg : setup_cfg;
    serial_cfg              = port_setting_switch ? fixed_cfg : setup_cfg;
    periph_cfg.console_mode = console_attached;
  end

  always_comb begin
    lamps_next               = '0;
    lamps_next.power         = supply_ok;
    lamps_next.execute       = running & ~fatal_err;
    if (periph_xfer || serial_xfer || (hold_reg != '0)) begin
      lamps_next.link_activity = flash;
    end
    if (fatal_err) begin
      lamps_next.fault = 1'b1;
    end else if (nonfatal_err) begin
      lamps_next.fault = flash;
    end
    lamps_next.console_sel   = OLD_REV & console_attached;

    // hold the link lamp briefly so a short burst is visible
    hold_next = '0;
    if (periph_xfer || serial_xfer) begin
      hold_next = CNT_W'(HOLD_CYC);
    end else if (hold_reg != '0) begin
      hold_next = hold_reg - CNT_W'(1);
    end

  end

  // io images and controller-side levels
  always_comb begin
    // input memory only refreshed while running; lamps ignore mode
    in_bits_next = in_bits_reg;
    if (running && io_refresh) begin
      in_bits_next = in_s2_reg;
    end

    out_lamps_next = out_lamps_reg;
    if (io_refresh) begin
      out_lamps_next = out_terms;
    end

    user_flag_next = user_flag_switch;

    // no-clock units leave detection off until enabled or setup cleared
    low_batt_next = batt_low & batt_detect_switch &
                    (~ctrl_reg[CTRL_NOCLK_BIT] | ctrl_reg[CTRL_BATTEN_BIT]);
  end

  // writes land in the access phase; read data is captured in the setup phase
  always_comb begin
    ctrl_next    = ctrl_reg;
    ev_en_next   = ev_en_reg;
    setup_next   = setup_reg;
    prdata_next  = prdata_reg;
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL:    ctrl_next = pwdata;
        ADDR_IRQ_EN:  ev_en_next = pwdata[NUM_EV-1:0];
        default: begin
          for (int i = 0; i < SETUP_WORDS; i++) begin
            if (setup_hit[i]) begin
              setup_next[i] = pwdata;
            end
          end
        end
      endcase
    end
    // setup clear wipes the words and turns detection on
    if (ctrl_reg[CTRL_SETUPCLR_BIT]) begin
      for (int i = 0; i < SETUP_WORDS; i++) begin
        setup_next[i] = '0;
      end
      ctrl_next[CTRL_SETUPCLR_BIT] = 1'b0;
      ctrl_next[CTRL_BATTEN_BIT]   = 1'b1;
    end
    if (rd_en) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        ADDR_CTRL:     prdata_next = ctrl_reg;
        ADDR_STATUS:   prdata_next = {24'h00_0000, 1'b0, port_setting_switch, batt_detect_switch,
                                      user_flag_reg, low_batt_reg, lamps_reg.fault, lamps_reg.execute,
                                      lamps_reg.power};
        ADDR_IRQ_STAT: prdata_next = {28'h000_0000, ev_stat_reg};
        ADDR_IRQ_EN:   prdata_next = {28'h000_0000, ev_en_reg};
        default: begin
          for (int i = 0; i < SETUP_WORDS; i++) begin
            if (setup_hit[i]) begin
              prdata_next = setup_reg[i];
            end
          end
        end
      endcase
    end
  end

  // sticky status: a write clears, a rising event or a setup clear sets
  always_comb begin
    ev_stat_next = ev_stat_reg;
    if (wr_en && (paddr == ADDR_IRQ_CLR)) begin
      ev_stat_next = ev_stat_reg & ~pwdata[NUM_EV-1:0];
    end
    if (ctrl_reg[CTRL_SETUPCLR_BIT]) begin
      ev_stat_next[EV_LOWBATT] = 1'b1;
    end
    // applied last so that setting wins over a clear in the same cycle
    ev_stat_next = ev_stat_next | (ev_raw & ~ev_prev_reg);
  end

  // pin synchronisers and the io images
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      in_s1_reg     <= '0;
      in_s2_reg     <= '0;
      in_bits_reg   <= '0;
      out_lamps_reg <= '0;
    end else begin
      // live terminals, no pulse stretching on the lamp path
      in_s1_reg     <= in_terms;
      in_s2_reg     <= in_s1_reg;
      in_bits_reg   <= in_bits_next;
      out_lamps_reg <= out_lamps_next;
    end
  end

  // lamps and the levels reported to the controller
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_reg      <= '0;
      user_flag_reg <= 1'b0;
      low_batt_reg  <= 1'b0;
      lamps_reg     <= '0;
    end else begin
      hold_reg      <= hold_next;
      user_flag_reg <= user_flag_next;
      low_batt_reg  <= low_batt_next;
      lamps_reg     <= lamps_next;
    end
  end

  // software registers; setup words come up cleared
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg      <= CTRL_RESET;
      for (int i = 0; i < SETUP_WORDS; i++) begin
        setup_reg[i] <= '0;
      end
      ev_en_reg     <= '0;
      prdata_reg    <= '0;
    end else begin
      ctrl_reg      <= ctrl_next;
      setup_reg     <= setup_next;
      ev_en_reg     <= ev_en_next;
      prdata_reg    <= prdata_next;
    end
  end

  // event history kept together so each edge is counted exactly once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ev_stat_reg   <= '0;
      ev_prev_reg   <= '0;
    end else begin
      ev_stat_reg   <= ev_stat_next;
      ev_prev_reg   <= ev_raw;
    end
  end

  assign lamps                = lamps_reg;
  assign in_lamps             = in_s2_reg;
  assign out_lamps            = out_lamps_reg;
  assign in_bits              = in_bits_reg;
  assign user_switch_flag_bit = user_flag_reg;
  assign low_batt_error       = low_batt_reg;
  assign irq                  = |(ev_stat_reg & ev_en_reg);
endmodule : csl_status_panel
`default_nettype wire

// ---- testbench/csl_status_panel_checker.sv ----
`default_nettype none
module csl_status_panel_checker
  import csl_pkg::*;
(
  // clock and reset
  input wire logic               mclk,
  input wire logic               nrst,
  // controller state
  input wire logic               supply_ok,
  input wire csl_mode_type       mode,
  input wire logic               fatal_err,
  input wire logic               nonfatal_err,
  input wire logic               console_attached,
  input wire logic               io_refresh,
  input wire logic [NUM_OUT-1:0] out_terms,
  input wire logic [NUM_IN-1:0]  in_terms,
  // observed outputs
  input wire csl_lamps_type      lamps,
  input wire logic [NUM_IN-1:0]  in_lamps,
  input wire logic [NUM_OUT-1:0] out_lamps,
  input wire logic [NUM_IN-1:0]  in_bits,
  input wire csl_port_cfg_type   serial_cfg
);
  // edges since reset release, so $past never looks into reset
  logic [1:0] age_reg;
  logic       run_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      age_reg <= 2'h0;
      run_reg <= 1'b0;
    end else begin
      age_reg <= (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
      run_reg <= (mode == MODE_EXECUTE || mode == MODE_OBSERVE) && !fatal_err;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  power_lamp_a: assert property (age_reg != 2'h0 |-> lamps.power == $past(supply_ok))
    else $error("power lamp wrong");
  exec_lamp_a: assert property (age_reg != 2'h0 |-> lamps.execute == run_reg)
    else $error("execute lamp wrong");
  fault_steady_a: assert property (age_reg != 2'h0 && $past(fatal_err) |-> lamps.fault)
    else $error("fault lamp not steady");
  fault_quiet_a: assert property (age_reg != 2'h0 && !$past(fatal_err) && !$past(nonfatal_err) |-> !lamps.fault)
    else $error("fault lamp lit");
  console_lamp_a: assert property (age_reg != 2'h0 |-> lamps.console_sel == $past(console_attached))
    else $error("console lamp wrong");
  in_lamp_track_a: assert property (age_reg[1] |-> in_lamps == $past(in_terms, 2))
    else $error("input lamps lag wrong");
  out_lamp_load_a: assert property (age_reg != 2'h0 && $past(io_refresh) |-> out_lamps == $past(out_terms))
    else $error("output lamps not loaded");
  out_lamp_hold_a: assert property (age_reg != 2'h0 && !$past(io_refresh) |-> $stable(out_lamps))
    else $error("output lamps moved");
  in_bits_frozen_a: assert property (age_reg != 2'h0 && $past(mode) == MODE_EDIT |-> $stable(in_bits))
    else $error("input bits refreshed");
  fixed_frame_a: assert property (!serial_cfg.use_setup |-> serial_cfg.data_bits == FIX_DATA_BITS
    && serial_cfg.stop_bits == FIX_STOP_BITS && serial_cfg.parity == PARITY_EVEN && serial_cfg.baud == FIX_BAUD)
    else $error("fixed framing wrong");
  cover property (fatal_err && nonfatal_err);
  cover property (io_refresh);
  cover property (!serial_cfg.use_setup);
endmodule : csl_status_panel_checker
bind csl_status_panel csl_status_panel_checker csl_status_panel_checker_inst (.mclk, .nrst, .supply_ok, .mode,
  .fatal_err, .nonfatal_err, .console_attached, .io_refresh, .out_terms, .in_terms, .lamps, .in_lamps,
  .out_lamps, .in_bits, .serial_cfg);
`default_nettype wire

// ---- testbench/csl_operator.sv ----
`default_nettype none
module csl_operator
  import csl_pkg::*;
(
  // clock
  input  wire logic              mclk,
  // wanted switch positions
  input  wire logic [NUM_SW-1:0] want_sw,
  // switch contacts
  output logic [NUM_SW-1:0]      panel_sw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NUM_SW-1:0] held_reg = '0;
  logic [1:0]        bounce_reg = 2'h0;
  // contacts chatter after each throw, so the panel must filter them
  always_ff @(posedge mclk) begin
    if (want_sw != held_reg) begin
      held_reg   <= want_sw;
      bounce_reg <= 2'h3;
    end else if (bounce_reg != 2'h0) begin
      bounce_reg <= bounce_reg - 2'h1;
    end
  end
  assign panel_sw = bounce_reg[0] ? ~held_reg : held_reg;
endmodule : csl_operator
`default_nettype wire

// ---- testbench/csl_status_panel_test.sv ----
`default_nettype none
module csl_status_panel_test
  import csl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic supply_ok, fatal_err, nonfatal_err, periph_xfer, serial_xfer;
  logic console_attached, batt_low, io_refresh, user_switch_flag_bit, low_batt_error, irq;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, w0, w1;
  logic [15:0]        in_terms, out_terms, in_lamps, out_lamps, in_bits;
  logic [2:0]         panel_sw, want_sw;
  csl_mode_type       mode;
  csl_lamps_type      lamps;
  csl_port_cfg_type   periph_cfg, serial_cfg;
  logic [32:0]        exp_q[$];
  int                 err_total, samples_checked, seed;

  csl_status_panel #(.DEB_CYC(4), .HOLD_CYC(4), .OLD_REV(1'b1)) csl_status_panel_inst (.mclk, .nrst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_ok, .mode, .fatal_err,
    .nonfatal_err, .periph_xfer, .serial_xfer, .console_attached, .batt_low, .io_refresh, .out_terms,
    .in_terms, .panel_sw, .lamps, .in_lamps, .out_lamps, .in_bits, .periph_cfg, .serial_cfg,
    .user_switch_flag_bit, .low_batt_error, .irq);
  // no expansion units hang off this bench, well inside the chain limit
  csl_operator csl_operator_inst (.mclk, .want_sw, .panel_sw);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [32:0] want, input logic [32:0] seen);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask : step

  // reads note the expected {pslverr, prdata} before the transfer starts
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    if (!wr) exp_q.push_back(e);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      close_out();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      check("apb read", exp_q.pop_front(), {pslverr, prdata});
  end

  initial begin
    step(20000);
    err_total++;
    close_out();
  end

  initial begin
    seed = 32'h749e;
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {fatal_err, nonfatal_err, periph_xfer, serial_xfer, console_attached, batt_low, io_refresh} = '0;
    {in_terms, out_terms, want_sw} = '0;
    supply_ok = 1'b1;
    mode = MODE_EDIT;
    step(2);
    nrst <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0, {1'b0, CTRL_RESET});
    apb(1'b0, ADDR_IRQ_EN, 32'h0, 33'h0);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) begin
      mode         <= csl_mode_type'(i % 3);
      fatal_err    <= i[0];
      nonfatal_err <= i[0];
      supply_ok    <= i[1];
      step(3);
      check("exec lamp", 33'((i % 3 != 0) && !i[0]), 33'(lamps.execute));
      check("fault lamp", 33'(i[0]), 33'(lamps.fault));
      check("power lamp", 33'(i[1]), 33'(lamps.power));
    end
    {fatal_err, nonfatal_err} <= 2'h0;
    supply_ok <= 1'b1;
    mode      <= MODE_EXECUTE;
    repeat (8) begin
      in_terms    <= 16'($random(seed));
      out_terms   <= 16'($random(seed));
      io_refresh  <= 1'($random(seed));
      periph_xfer <= 1'($random(seed));
      serial_xfer <= 1'($random(seed));
      step(1);
    end
    {io_refresh, periph_xfer, serial_xfer} <= 3'h0;
    step(4);
    check("input lamps", 33'(in_terms), 33'(in_lamps));
    io_refresh <= 1'b1;
    step(1);
    io_refresh <= 1'b0;
    step(2);
    check("input bits", 33'(in_terms), 33'(in_bits));
    check("output lamps", 33'(out_terms), 33'(out_lamps));
    check("link lamp idle", 33'h0, 33'(lamps.link_activity));
    want_sw <= 3'h1;
    step(20);
    check("fixed frame", 33'({FIX_BAUD, FIX_DATA_BITS, FIX_STOP_BITS, FIX_START_BITS, PARITY_EVEN}),
      33'({serial_cfg.baud, serial_cfg.data_bits, serial_cfg.stop_bits, serial_cfg.start_bits,
      serial_cfg.parity}));
    console_attached <= 1'b1;
    step(3);
    check("console mode", 33'h1, 33'(periph_cfg.console_mode));
    check("console lamp", 33'h1, 33'(lamps.console_sel));
    console_attached <= 1'b0;
    w0 = 32'($random(seed)) & 32'h0000_03FF;
    w1 = 32'($random(seed)) & 32'h0000_FFFF;
    apb(1'b1, ADDR_SETUP0, w0, 33'h0);
    apb(1'b1, ADDR_SETUP0 + 8'h04, w1, 33'h0);
    want_sw <= 3'h0;
    step(20);
    check("setup frame", {1'b1, w1[15:0], w0[9:0]}, 33'({serial_cfg.use_setup, serial_cfg.baud,
      serial_cfg.parity, serial_cfg.start_bits, serial_cfg.stop_bits, serial_cfg.data_bits}));
    want_sw <= 3'h2;
    step(20);
    check("user flag", 33'h1, 33'(user_switch_flag_bit));
    apb(1'b0, ADDR_STATUS, 32'h0, 33'h13);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, 33'hB);
    apb(1'b1, ADDR_IRQ_CLR, 32'hF, 33'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, 33'h0);
    apb(1'b1, ADDR_IRQ_EN, 32'h4, 33'h0);
    batt_low <= 1'b1;
    want_sw  <= 3'h4;
    step(20);
    check("low batt fwd", 33'h1, 33'(low_batt_error));
    check("irq raised", 33'h1, 33'(irq));
    apb(1'b1, ADDR_IRQ_EN, 32'h0, 33'h0);
    step(2);
    check("irq masked", 33'h0, 33'(irq));
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, 33'hC);
    apb(1'b1, ADDR_IRQ_CLR, 32'hC, 33'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, 33'h0);
    want_sw <= 3'h0;
    step(20);
    check("low batt back", 33'h0, 33'(low_batt_error));
    apb(1'b1, ADDR_CTRL, 32'h1, 33'h0);
    want_sw <= 3'h4;
    step(20);
    check("no clock unit", 33'h0, 33'(low_batt_error));
    apb(1'b1, ADDR_CTRL, 32'h3, 33'h0);
    step(3);
    check("setup clear", 33'h1, 33'(low_batt_error));
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, 33'h4);
    step(2);
    close_out();
  end
endmodule : csl_status_panel_test
`default_nettype wire
